//--- rtl/pscr_params.svh
`ifndef PSCR_PARAMS_SVH
`define PSCR_PARAMS_SVH
// ***********************************************
// Register word addresses
// ***********************************************
`define PSCR_ADDR_INPUT_CONTROL 8'h00
`define PSCR_ADDR_LOOP_CONTROL 8'h01
`define PSCR_ADDR_FB_DIV_LOW 8'h02
`define PSCR_ADDR_FB_DIV_HIGH 8'h03
`define PSCR_ADDR_RESERVED_FOUR 8'h04
`define PSCR_ADDR_COND 8'h05
`define PSCR_ADDR_OUT_EN 8'h06
`define PSCR_ADDR_COMMIT 8'h08
`define PSCR_ADDR_CHIP_REV 8'h11
`define PSCR_ADDR_STATUS 8'h12
`define PSCR_COMMIT_KEY 8'h5A
// ***********************************************
// Reset values and writable masks
// ***********************************************
`define PSCR_RST_INPUT_CONTROL 8'h41
`define PSCR_RST_LOOP_CONTROL 8'h03
`define PSCR_RST_FB_DIV_LOW 8'h04
`define PSCR_RST_FB_DIV_HIGH 8'h00
`define PSCR_RST_COND 8'h01
`define PSCR_RST_OUT_EN 8'h00
`define PSCR_RST_FB_RATIO 13'h000C
`define PSCR_MASK_INPUT_CONTROL 8'h5F
`define PSCR_MASK_LOOP_CONTROL 8'h37
`define PSCR_MASK_FB_DIV_HIGH 8'h0F
`define PSCR_MASK_COND 8'h01
`define PSCR_MASK_OUT_EN 8'h02
// ***********************************************
// Field positions
// ***********************************************
`define PSCR_IC_ALWAYS_ON 0
`define PSCR_IC_COAST_POL 1
`define PSCR_IC_HS_POL 2
`define PSCR_IC_FB_POL 3
`define PSCR_IC_FB_SEL 4
`define PSCR_IC_LOCK_EN 6
`define PSCR_OE_BIT 1
`define PSCR_COND_BYPASS 0
`define PSCR_LOOP_DIV_LSB 4
// ***********************************************
// Bus address and divider limits
// ***********************************************
`define PSCR_DEV_ADDR_BASE 6'h13
`define PSCR_FB_RATIO_OFFSET 13'h0008
`define PSCR_FB_RATIO_MIN 13'h000C
`define PSCR_FB_RATIO_MAX 13'h1007
`endif

//--- rtl/pscr_pkg.sv
package pscr_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} pscr_wr_t;

	typedef struct packed {
		logic always_on;
		logic coast_pol;
		logic hs_pol;
		logic fb_pol;
		logic fb_sel;
		logic bypass;
		logic [12:0] fb_ratio;
	} pscr_cfg_t;

	typedef enum logic [3:0] {
		PSCR_IDLE = 4'h0,
		PSCR_ADDR = 4'h1,
		PSCR_AACK = 4'h2,
		PSCR_PTR = 4'h3,
		PSCR_PACK = 4'h4,
		PSCR_WR = 4'h5,
		PSCR_WACK = 4'h6,
		PSCR_RD = 4'h7,
		PSCR_RACK = 4'h8
	} pscr_bus_st_t;
endpackage

//--- rtl/pscr_i2c_slave.sv
`timescale 1ns/1ps
`include "pscr_params.svh"
module pscr_i2c_slave
	import pscr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_addr_sel,
	output logic o_sda_o,
	output logic o_sda_oe,
	output pscr_wr_t o_wr,
	output logic [7:0] o_rd_addr,
	input wire logic [7:0] i_rd_data
);
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] sel_s;
		pscr_bus_st_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rnw;
		logic nack;
		logic oe;
		pscr_wr_t wr;
	} pscr_slv_t;

	pscr_slv_t s, n;
	logic start, stop, rise, fall;

	// Pointer wraps inside its 16-byte page
	function automatic logic [7:0] page_inc(input logic [7:0] p);
		page_inc = {p[7:4], p[3:0] + 4'h1};
	endfunction

	assign rise = s.scl_s[1] & ~s.scl_s[2];
	assign fall = ~s.scl_s[1] & s.scl_s[2];
	assign start = s.scl_s[1] & s.scl_s[2] & s.sda_s[2] & ~s.sda_s[1];
	assign stop = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[2] & s.sda_s[1];

	always_comb
	begin
		n = s;
		n.scl_s = {s.scl_s[1:0], i_scl};
		n.sda_s = {s.sda_s[1:0], i_sda};
		n.sel_s = {s.sel_s[0], i_addr_sel};
		n.wr.valid = 1'b0;
		if (start)
		begin
			n.st = PSCR_ADDR;
			n.cnt = 4'h0;
			n.oe = 1'b0;
		end
		else if (stop)
		begin
			n.st = PSCR_IDLE;
			n.oe = 1'b0;
		end
		else if (rise)
		begin
			if (s.st == PSCR_ADDR || s.st == PSCR_PTR || s.st == PSCR_WR)
			begin
				n.sh = {s.sh[6:0], s.sda_s[1]};
				n.cnt = s.cnt + 4'h1;
			end
			else if (s.st == PSCR_RD)
				n.cnt = s.cnt + 4'h1;
			else if (s.st == PSCR_RACK)
				n.nack = s.sda_s[1];
		end
		else if (fall)
		begin
			unique case (s.st)
				PSCR_IDLE:
					n.oe = 1'b0;
				PSCR_ADDR:
					if (s.cnt == 4'h8)
					begin
						if (s.sh[7:1] == {`PSCR_DEV_ADDR_BASE, s.sel_s[1]})
						begin
							n.oe = 1'b1;
							n.rnw = s.sh[0];
							n.st = PSCR_AACK;
						end
						else
							n.st = PSCR_IDLE;
					end
				PSCR_AACK, PSCR_RACK:
					if ((s.st == PSCR_AACK && s.rnw) ||
						(s.st == PSCR_RACK && !s.nack))
					begin
						n.sh = i_rd_data;
						n.oe = ~i_rd_data[7];
						n.cnt = 4'h0;
						n.st = PSCR_RD;
					end
					else
					begin
						n.oe = 1'b0;
						n.cnt = 4'h0;
						n.st = (s.st == PSCR_AACK) ? PSCR_PTR : PSCR_IDLE;
					end
				PSCR_PTR:
					if (s.cnt == 4'h8)
					begin
						n.ptr = s.sh;
						n.oe = 1'b1;
						n.st = PSCR_PACK;
					end
				PSCR_PACK, PSCR_WACK:
				begin
					n.oe = 1'b0;
					n.cnt = 4'h0;
					n.st = PSCR_WR;
				end
				PSCR_WR:
					if (s.cnt == 4'h8)
					begin
						n.wr = '{valid: 1'b1, addr: s.ptr, data: s.sh};
						n.ptr = page_inc(s.ptr);
						n.oe = 1'b1;
						n.st = PSCR_WACK;
					end
				PSCR_RD:
					if (s.cnt == 4'h8)
					begin
						n.oe = 1'b0;
						n.ptr = page_inc(s.ptr);
						n.st = PSCR_RACK;
					end
					else
					begin
						n.sh = {s.sh[6:0], 1'b0};
						n.oe = ~s.sh[6];
					end
				default:
				begin
					n.oe = 1'b0;
					n.st = PSCR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= '{scl_s: 3'h7, sda_s: 3'h7, st: PSCR_IDLE, default: '0};
		else
			s <= n;
	end

	assign o_sda_o = 1'b0;
	assign o_sda_oe = s.oe;
	assign o_wr = s.wr;
	assign o_rd_addr = s.ptr;

	AST_ADDR_MISMATCH: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		(s.st == PSCR_ADDR && fall && !start && !stop && s.cnt == 4'h8 &&
		s.sh[7:1] != {`PSCR_DEV_ADDR_BASE, s.sel_s[1]}) |=>
		(s.st == PSCR_IDLE && !o_sda_oe))
		else $error("foreign device address was acknowledged");
endmodule

//--- rtl/pscr_top.sv
`timescale 1ns/1ps
`include "pscr_params.svh"
module pscr_top
	import pscr_pkg::*;
#(
	// Arbitrary identification values
	parameter logic [7:0] P_CHIP_REV = 8'hA5,
	parameter logic [6:0] P_METAL_REV = 7'h2C
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	input wire logic i_bus_address_select,
	input wire logic i_pll_lock,
	output logic o_lock,
	output logic o_out_oe,
	output logic [2:0] o_pump_current_code,
	output logic [1:0] o_osc_post_divider_code,
	output logic [12:0] o_fb_ratio,
	output logic o_schmitt_bypass,
	output logic o_pll_restart,
	input wire logic i_pix_clk,
	input wire logic i_hsync,
	input wire logic i_vsync,
	input wire logic i_external_feedback_in,
	output logic o_hsync_out,
	output logic o_vsync_out,
	output logic o_pump_enable,
	output logic o_ref_edge,
	output logic o_fb_edge
);
	// ***********************************************
	// Register file state (bus clock)
	// ***********************************************
	typedef struct packed {
		logic [7:0] in_ctl;
		logic [7:0] loop_sh;
		logic [7:0] fbl_sh;
		logic [7:0] fbh_sh;
		logic [7:0] cond_sh;
		logic [7:0] loop_act;
		logic [7:0] fbl_act;
		logic [7:0] fbh_act;
		logic [7:0] cond_act;
		logic [7:0] out_en;
		logic [1:0] lock_s;
		logic lock_out;
		logic restart;
		logic commit_tog;
		logic [12:0] ratio;
	} pscr_core_t;

	// ***********************************************
	// Link state (pixel clock)
	// ***********************************************
	typedef struct packed {
		pscr_cfg_t cfg1;
		pscr_cfg_t cfg2;
		logic [2:0] tog;
		logic [2:0] hs_s;
		logic [2:0] vs_s;
		logic [2:0] fb_s;
		logic hs_c;
		logic vs_c;
		logic hs_prev;
		logic [12:0] cnt;
		logic pump;
		logic ref_e;
		logic fb_e;
	} pscr_pix_t;

	localparam pscr_core_t CORE_RST = '{
		in_ctl: `PSCR_RST_INPUT_CONTROL,
		loop_sh: `PSCR_RST_LOOP_CONTROL,
		fbl_sh: `PSCR_RST_FB_DIV_LOW,
		fbh_sh: `PSCR_RST_FB_DIV_HIGH,
		cond_sh: `PSCR_RST_COND,
		loop_act: `PSCR_RST_LOOP_CONTROL,
		fbl_act: `PSCR_RST_FB_DIV_LOW,
		fbh_act: `PSCR_RST_FB_DIV_HIGH,
		cond_act: `PSCR_RST_COND,
		out_en: `PSCR_RST_OUT_EN,
		ratio: `PSCR_RST_FB_RATIO,
		default: '0
	};

	pscr_core_t s, n;
	pscr_pix_t p, q;
	pscr_wr_t wr;
	pscr_cfg_t cfg_c;
	logic [7:0] rd_addr, rd_data;
	logic commit, ext_e, int_e, tog_e;

	// Values below the legal minimum are held at the shortest ratio
	function automatic logic [12:0] fb_ratio(input logic [7:0] hi,
		input logic [7:0] lo);
		logic [12:0] r;
		r = {1'b0, hi[3:0], lo} + `PSCR_FB_RATIO_OFFSET;
		fb_ratio = (r < `PSCR_FB_RATIO_MIN) ? `PSCR_FB_RATIO_MIN : r;
	endfunction

	pscr_i2c_slave pscr_i2c_slave_i (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.i_addr_sel(i_bus_address_select),
		.o_sda_o(o_sda_o),
		.o_sda_oe(o_sda_oe),
		.o_wr(wr),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data)
	);

	// ***********************************************
	// Register read and write
	// ***********************************************
	always_comb
	begin
		case (rd_addr)
			`PSCR_ADDR_INPUT_CONTROL: rd_data = s.in_ctl;
			`PSCR_ADDR_LOOP_CONTROL: rd_data = s.loop_sh;
			`PSCR_ADDR_FB_DIV_LOW: rd_data = s.fbl_sh;
			`PSCR_ADDR_FB_DIV_HIGH: rd_data = s.fbh_sh;
			`PSCR_ADDR_COND: rd_data = {P_METAL_REV, s.cond_sh[0]};
			`PSCR_ADDR_OUT_EN: rd_data = s.out_en;
			`PSCR_ADDR_CHIP_REV: rd_data = P_CHIP_REV;
			`PSCR_ADDR_STATUS: rd_data = {6'h00, s.lock_s[1], 1'b0};
			default: rd_data = 8'h00;
		endcase
	end

	assign commit = wr.valid && wr.addr == `PSCR_ADDR_COMMIT &&
		wr.data == `PSCR_COMMIT_KEY;

	always_comb
	begin
		n = s;
		n.lock_s = {s.lock_s[0], i_pll_lock};
		n.lock_out = s.lock_s[1] & s.in_ctl[`PSCR_IC_LOCK_EN];
		n.restart = 1'b0;
		if (wr.valid)
		begin
			case (wr.addr)
				`PSCR_ADDR_INPUT_CONTROL:
					n.in_ctl = wr.data & `PSCR_MASK_INPUT_CONTROL;
				`PSCR_ADDR_LOOP_CONTROL:
					n.loop_sh = wr.data & `PSCR_MASK_LOOP_CONTROL;
				`PSCR_ADDR_FB_DIV_LOW:
					n.fbl_sh = wr.data;
				`PSCR_ADDR_FB_DIV_HIGH:
					n.fbh_sh = wr.data & `PSCR_MASK_FB_DIV_HIGH;
				`PSCR_ADDR_COND:
					n.cond_sh = wr.data & `PSCR_MASK_COND;
				`PSCR_ADDR_OUT_EN:
					n.out_en = wr.data & `PSCR_MASK_OUT_EN;
				default:
					n.out_en = s.out_en;
			endcase
		end
		// Shadows reach the loop only on the key write
		if (commit)
		begin
			n.loop_act = s.loop_sh;
			n.fbl_act = s.fbl_sh;
			n.fbh_act = s.fbh_sh;
			n.cond_act = s.cond_sh;
			n.ratio = fb_ratio(s.fbh_sh, s.fbl_sh);
			n.restart = 1'b1;
			n.commit_tog = ~s.commit_tog;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= CORE_RST;
		else
			s <= n;
	end

	assign o_lock = s.lock_out;
	assign o_out_oe = s.out_en[`PSCR_OE_BIT];
	assign o_pump_current_code = s.loop_act[2:0];
	assign o_osc_post_divider_code =
		s.loop_act[`PSCR_LOOP_DIV_LSB +: 2];
	assign o_fb_ratio = s.ratio;
	assign o_schmitt_bypass = s.cond_act[`PSCR_COND_BYPASS];
	assign o_pll_restart = s.restart;

	// ***********************************************
	// Link logic (pixel clock)
	// ***********************************************
	// Config is quasi-static; a change settles in two pixel clocks
	assign cfg_c = '{
		always_on: s.in_ctl[`PSCR_IC_ALWAYS_ON],
		coast_pol: s.in_ctl[`PSCR_IC_COAST_POL],
		hs_pol: s.in_ctl[`PSCR_IC_HS_POL],
		fb_pol: s.in_ctl[`PSCR_IC_FB_POL],
		fb_sel: s.in_ctl[`PSCR_IC_FB_SEL],
		bypass: s.cond_act[`PSCR_COND_BYPASS],
		fb_ratio: s.ratio
	};

	assign tog_e = p.tog[1] ^ p.tog[2];
	assign ext_e = (p.fb_s[1] != p.fb_s[2]) &&
		(p.fb_s[1] != p.cfg2.fb_pol);
	assign int_e = p.cnt >= p.cfg2.fb_ratio - 13'h0001;

	always_comb
	begin
		q = p;
		q.cfg1 = cfg_c;
		q.cfg2 = p.cfg1;
		q.tog = {p.tog[1:0], s.commit_tog};
		q.hs_s = {p.hs_s[1:0], i_hsync};
		q.vs_s = {p.vs_s[1:0], i_vsync};
		q.fb_s = {p.fb_s[1:0], i_external_feedback_in};
		// Conditioning: a level must hold two samples before it is taken
		if (p.cfg2.bypass || p.hs_s[1] == p.hs_s[2])
			q.hs_c = p.hs_s[1];
		if (p.cfg2.bypass || p.vs_s[1] == p.vs_s[2])
			q.vs_c = p.vs_s[1];
		q.hs_prev = p.hs_c;
		q.ref_e = (p.hs_prev != p.hs_c) && (p.hs_c != p.cfg2.hs_pol);
		q.pump = p.cfg2.always_on | (p.vs_c ^ p.cfg2.coast_pol);
		q.cnt = (tog_e || int_e) ? 13'h0000 : p.cnt + 13'h0001;
		q.fb_e = p.cfg2.fb_sel ? ext_e : (int_e && !tog_e);
	end

	always_ff @(posedge i_pix_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			p <= '0;
		else
			p <= q;
	end

	assign o_hsync_out = p.hs_c;
	assign o_vsync_out = p.vs_c;
	assign o_pump_enable = p.pump;
	assign o_ref_edge = p.ref_e;
	assign o_fb_edge = p.fb_e;

	// ***********************************************
	// Checks
	// ***********************************************
	AST_PUMP_ON: assert property (@(posedge i_pix_clk)
		disable iff (!i_arst_n)
		p.cfg2.always_on |=> o_pump_enable)
		else $error("pump gated while always-on is set");
	AST_COAST: assert property (@(posedge i_pix_clk)
		disable iff (!i_arst_n)
		(!p.cfg2.always_on && p.vs_c == p.cfg2.coast_pol) |=> !o_pump_enable)
		else $error("pump not coasting at the coast level");
	AST_REF_EDGE: assert property (@(posedge i_pix_clk)
		disable iff (!i_arst_n)
		(p.hs_prev != p.hs_c) |=> (o_ref_edge == ($past(p.hs_c) !=
		$past(p.cfg2.hs_pol))))
		else $error("reference edge on wrong polarity");
	AST_EXT_FB: assert property (@(posedge i_pix_clk)
		disable iff (!i_arst_n)
		(p.cfg2.fb_sel && p.fb_s[1] != p.fb_s[2]) |=>
		(o_fb_edge == ($past(p.fb_s[1]) != $past(p.cfg2.fb_pol))))
		else $error("external feedback edge on wrong polarity");
	// Last count of a minimum-ratio period must end it with one pulse
	AST_INT_FB: assert property (@(posedge i_pix_clk)
		disable iff (!i_arst_n)
		(!p.cfg2.fb_sel && p.cnt == 13'h000B && !tog_e &&
		p.cfg2.fb_ratio == `PSCR_FB_RATIO_MIN) |=>
		(o_fb_edge && !$past(o_fb_edge)))
		else $error("internal divider period wrong");
	AST_LOCK_GATE: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		!s.in_ctl[`PSCR_IC_LOCK_EN] |=> !o_lock)
		else $error("lock output active while disabled");
	AST_RATIO_RANGE: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		o_fb_ratio >= `PSCR_FB_RATIO_MIN && o_fb_ratio <= `PSCR_FB_RATIO_MAX)
		else $error("feedback ratio out of range");
	AST_NO_EARLY: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		!commit |=> ($stable(o_pump_current_code) && $stable(o_fb_ratio) &&
		$stable(o_schmitt_bypass)))
		else $error("loop setting changed without commit");
	AST_COMMIT: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		commit |=> (s.loop_act == $past(s.loop_sh) && o_pll_restart) ##1
		!o_pll_restart)
		else $error("commit did not apply shadow values");
	AST_OE: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		(wr.valid && wr.addr == `PSCR_ADDR_OUT_EN) |=>
		(o_out_oe == $past(wr.data[`PSCR_OE_BIT])))
		else $error("output enable did not follow write");
	AST_STATUS: assert property (@(posedge i_clk)
		disable iff (!i_arst_n)
		(rd_addr == `PSCR_ADDR_STATUS |-> rd_data[1] == s.lock_s[1]) and
		(rd_addr == `PSCR_ADDR_COND |-> rd_data[7:1] == P_METAL_REV))
		else $error("status or revision read wrong");
	AST_BYPASS: assert property (@(posedge i_pix_clk)
		disable iff (!i_arst_n)
		(p.cfg2.bypass && p.hs_s[1] != p.hs_c) |=> $changed(o_hsync_out))
		else $error("bypassed hsync was filtered");

	COV_COMMIT: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		commit);
	COV_REF: cover property (@(posedge i_pix_clk) disable iff (!i_arst_n)
		o_ref_edge && p.cfg2.hs_pol);
	COV_INT_FB: cover property (@(posedge i_pix_clk) disable iff (!i_arst_n)
		o_fb_edge && !p.cfg2.fb_sel);
	COV_COAST: cover property (@(posedge i_pix_clk) disable iff (!i_arst_n)
		!o_pump_enable && !p.cfg2.always_on);
endmodule

//--- testbench/pscr_bus_master.sv
`timescale 1ns/1ps
// ****
// Two-wire master, open drain on data
// ****
module pscr_bus_master
(
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	// Quarter bit in clocks; raise it for a slow master
	int q = 8;
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n * q) @(posedge i_clk);
		#1;
	endtask
	task automatic bit_out(input logic b);
		o_sda_oe = ~b;
		tick(1);
		o_scl = 1'b1;
		tick(2);
		o_scl = 1'b0;
		tick(1);
	endtask
	// Sampled late in the high phase, once the slave has settled
	task automatic bit_in(output logic b);
		o_sda_oe = 1'b0;
		tick(1);
		o_scl = 1'b1;
		tick(2);
		b = i_sda;
		o_scl = 1'b0;
		tick(1);
	endtask
	task automatic start();
		o_sda_oe = 1'b0;
		tick(1);
		o_scl = 1'b1;
		tick(1);
		o_sda_oe = 1'b1;
		tick(1);
		o_scl = 1'b0;
		tick(1);
	endtask
	task automatic stop();
		o_sda_oe = 1'b1;
		tick(1);
		o_scl = 1'b1;
		tick(1);
		o_sda_oe = 1'b0;
		tick(2);
	endtask
	task automatic send(input logic [7:0] b, output logic nak);
		for (int i = 7; i >= 0; i--)
			bit_out(b[i]);
		bit_in(nak);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d, output logic [2:0] nak);
		start();
		send({dev, 1'b0}, nak[2]);
		send(ptr, nak[1]);
		send(d, nak[0]);
		stop();
	endtask
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] d, output logic [2:0] nak);
		start();
		send({dev, 1'b0}, nak[2]);
		send(ptr, nak[1]);
		start();
		send({dev, 1'b1}, nak[0]);
		for (int i = 7; i >= 0; i--)
			bit_in(d[i]);
		bit_out(1'b1);
		stop();
	endtask
endmodule

//--- testbench/test_pscr_top.sv
`timescale 1ns/1ps
module test_pscr_top;
	logic i_clk = 1'b0;
	logic pix = 1'b0;
	logic arst_n = 1'b0;
	logic sel = 1'b0;
	logic lock_in = 1'b0;
	logic hs = 1'b0;
	logic vs = 1'b0;
	logic efb = 1'b0;
	logic scl, m_oe, sda_oe, sda_o, lock, out_oe, byp, rst_p;
	logic hso, vso, pump_en, ref_e, fb_e;
	logic [2:0] pump;
	logic [1:0] post;
	logic [12:0] ratio;
	logic [7:0] rd_d;
	logic [2:0] nak;
	logic [2:0] pc [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
	logic [4:0] prev;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int n_ref = 0;
	int n_fb = 0;
	int n_rst = 0;
	// Pull-up on the data line
	wire sda = ~(m_oe | (sda_oe & ~sda_o));
	always #5 i_clk = ~i_clk;
	initial
	begin
		#7.3;
		forever #40 pix = ~pix;
	end
	pscr_bus_master pscr_bus_master_i (.i_clk(i_clk), .i_sda(sda),
		.o_scl(scl), .o_sda_oe(m_oe));
	pscr_top pscr_top_i (.i_clk(i_clk), .i_arst_n(arst_n), .i_scl(scl),
		.i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.i_bus_address_select(sel), .i_pll_lock(lock_in), .o_lock(lock),
		.o_out_oe(out_oe), .o_pump_current_code(pump),
		.o_osc_post_divider_code(post), .o_fb_ratio(ratio),
		.o_schmitt_bypass(byp), .o_pll_restart(rst_p), .i_pix_clk(pix),
		.i_hsync(hs), .i_vsync(vs), .i_external_feedback_in(efb),
		.o_hsync_out(hso), .o_vsync_out(vso), .o_pump_enable(pump_en),
		.o_ref_edge(ref_e), .o_fb_edge(fb_e));
	// ****
	// Checking and closing
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			err_count++;
			finish_test();
		end
	end
	// Pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge i_clk)
	begin
		if (rst_p === 1'b1)
			n_rst++;
	end
	always @(negedge pix)
	begin
		if (ref_e === 1'b1)
			n_ref++;
		if (fb_e === 1'b1)
			n_fb++;
	end
	task automatic clkw(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic pixw(input int n);
		repeat (n) @(posedge pix);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		pscr_bus_master_i.wr(7'h26, a, d, nak);
		check(16'(nak), 16'h0000);
		clkw(3);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		pscr_bus_master_i.rd(7'h26, a, rd_d, nak);
		check(16'({nak, rd_d}), 16'(exp));
	endtask
	// ****
	// Tests
	// ****
	initial
	begin
		// Slow domain needs at least two edges inside reset
		repeat (3) @(posedge pix);
		#1;
		arst_n = 1'b1;
		clkw(3);
		check(16'({out_oe, byp, ratio}), 16'h200C);
		rchk(8'h00, 8'h41);
		rchk(8'h05, 8'h59);
		rchk(8'h06, 8'h00);
		rchk(8'h04, 8'h00);
		check(16'(pump_en), 16'h0001);
		$display("reset test end");
		lock_in = 1'b1;
		rchk(8'h12, 8'h02);
		check(16'(lock), 16'h0001);
		wreg(8'h00, 8'h01);
		check(16'(lock), 16'h0000);
		lock_in = 1'b0;
		rchk(8'h12, 8'h00);
		wreg(8'h06, 8'hFF);
		check(16'(out_oe), 16'h0001);
		rchk(8'h06, 8'h02);
		wreg(8'h06, 8'h00);
		check(16'(out_oe), 16'h0000);
		$display("lock and enable test end");
		prev = 5'h03;
		for (int i = 0; i < 5; i++)
		begin
			wreg(8'h01, {2'h0, 2'(i), 1'b0, pc[i]});
			check(16'({post, pump}), 16'(prev));
			wreg(8'h08, 8'h5A);
			prev = {2'(i), pc[i]};
			check(16'({post, pump}), 16'(prev));
		end
		wreg(8'h01, 8'h03);
		wreg(8'h08, 8'h5B);
		check(16'(pump), 16'h0007);
		check(16'(n_rst), 16'h0005);
		wreg(8'h02, 8'hFF);
		wreg(8'h03, 8'hFF);
		rchk(8'h03, 8'h0F);
		wreg(8'h08, 8'h5A);
		check(16'({pump, ratio}), 16'h7007);
		wreg(8'h02, 8'h08);
		wreg(8'h03, 8'h00);
		wreg(8'h08, 8'h5A);
		check(16'(ratio), 16'h0010);
		pixw(10);
		n_fb = 0;
		pixw(64);
		check(16'(n_fb), 16'h0004);
		wreg(8'h05, 8'h00);
		check(16'(byp), 16'h0001);
		rchk(8'h05, 8'h58);
		wreg(8'h08, 8'h5A);
		check(16'(byp), 16'h0000);
		$display("commit test end");
		wreg(8'h00, 8'h00);
		pixw(6);
		check(16'(pump_en), 16'h0000);
		vs = 1'b1;
		pixw(6);
		check(16'(pump_en), 16'h0001);
		check(16'(vso), 16'h0001);
		wreg(8'h00, 8'h02);
		pixw(6);
		check(16'(pump_en), 16'h0000);
		vs = 1'b0;
		pixw(6);
		check(16'(pump_en), 16'h0001);
		n_ref = 0;
		hs = 1'b1;
		pixw(8);
		check(16'(n_ref), 16'h0001);
		check(16'(hso), 16'h0001);
		hs = 1'b0;
		pixw(8);
		check(16'(n_ref), 16'h0001);
		wreg(8'h00, 8'h06);
		pixw(4);
		n_ref = 0;
		hs = 1'b1;
		pixw(8);
		check(16'(n_ref), 16'h0000);
		hs = 1'b0;
		pixw(8);
		check(16'(n_ref), 16'h0001);
		$display("sync test end");
		wreg(8'h00, 8'h10);
		pixw(6);
		n_fb = 0;
		pixw(40);
		check(16'(n_fb), 16'h0000);
		efb = 1'b1;
		pixw(8);
		check(16'(n_fb), 16'h0001);
		wreg(8'h00, 8'h18);
		pixw(4);
		n_fb = 0;
		efb = 1'b0;
		pixw(8);
		check(16'(n_fb), 16'h0001);
		$display("feedback test end");
		sel = 1'b1;
		clkw(4);
		pscr_bus_master_i.wr(7'h26, 8'h06, 8'h02, nak);
		check(16'({nak, out_oe}), 16'h000E);
		pscr_bus_master_i.q = 20;
		pscr_bus_master_i.rd(7'h27, 8'h00, rd_d, nak);
		check(16'({nak, rd_d}), 16'h0018);
		pscr_bus_master_i.q = 8;
		$display("address test end");
		finish_test();
	end
endmodule
